/* File: bench/mrst_proc.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Processor reset input behind a pull-up.
module mrst_proc (
	input wire logic clk, // Clock.
	input wire logic rn, // Driven pin level.
	input wire logic oe, // Pin drive enable.
	output int cnt, // Completed pulses.
	output int w // Width of the last pulse.
);
	wire logic line = oe ? rn : 1'b1; // Released pin floats up to the pull-up level.
	int c = 0;
	initial cnt = 0;
	// A pulse is counted on its trailing edge, so only whole pulses count.
	always @(posedge clk)
	begin
		c <= line ? 0 : c + 1;
		if (line && c > 0)
		begin
			cnt <= cnt + 1;
			w <= c;
		end
	end
endmodule
`default_nettype wire

/* File: bench/mrst_timer_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker; long counts live in counters, not repetitions.
module mrst_timer_checker #(
	parameter longint HOLD_CYCLES = 20,
	parameter bit LONG_PULSE = 1'b0,
	parameter longint TEST_DELAY_CYCLES = 10,
	parameter longint TEST_WINDOW_CYCLES = 60,
	parameter longint SHORT_PULSE_CYCLES = 200,
	parameter longint LONG_PULSE_CYCLES = 400
) (
	input wire logic CLK_SYS, // Clock.
	input wire logic RST, // Reset.
	input wire logic FIRST_MANUAL_INPUT_N, // First input.
	input wire logic SECOND_MANUAL_INPUT_N, // Second input.
	input wire logic RESET_OUT_N, // Pin level.
	input wire logic RESET_OUT_OE, // Pin drive.
	input wire logic TEST_ACTIVE // Test mode.
);
	localparam longint PW = LONG_PULSE ? LONG_PULSE_CYCLES : SHORT_PULSE_CYCLES;
	wire logic f = FIRST_MANUAL_INPUT_N;
	wire logic s = SECOND_MANUAL_INPUT_N;
	wire logic oe = RESET_OUT_OE;
	longint low_q = 0;
	longint hi_q = 0;
	longint ta_q = 0;
	int rise_q = 0;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// Time both low, time driven, time in test, and test clock edges.
	always_ff @(posedge CLK_SYS)
	begin
		low_q <= (f | s) ? 0 : low_q + 1;
		hi_q <= oe ? hi_q + 1 : 0;
		ta_q <= TEST_ACTIVE ? ta_q + 1 : 0;
		rise_q <= f ? 0 : rise_q + (s & !$past(s));
	end
	a_no_early: assert property ($rose(oe) && !$past(TEST_ACTIVE) && !$past(TEST_ACTIVE, 2) |->
		low_q > HOLD_CYCLES) else $error("pulse before hold time");
	a_pulse_due: assert property (low_q == HOLD_CYCLES + 6 |-> oe) else $error("pulse missing");
	a_one_pulse: assert property ($rose(oe) |-> low_q < HOLD_CYCLES + 8) else $error("second pulse");
	a_pulse_width: assert property ($fell(oe) |-> hi_q >= PW && hi_q <= PW + 2) else $error("bad width");
	a_drive_low: assert property (oe |-> !RESET_OUT_N) else $error("pin driven high");
	a_quiet_start: assert property ($past(RST) |-> !oe && !TEST_ACTIVE) else $error("pulse at start");
	a_test_delay: assert property ($rose(oe) && $past(TEST_ACTIVE) |->
		ta_q >= TEST_DELAY_CYCLES && ta_q <= TEST_DELAY_CYCLES + 3) else $error("bad test delay");
	a_test_exit: assert property ($rose(oe) |=> !TEST_ACTIVE [*4]) else $error("test mode kept");
	a_test_entry: assert property ($rose(TEST_ACTIVE) |-> rise_q >= 8 && !f) else $error("early entry");
	a_test_abort: assert property ((f && s) [*5] |-> !TEST_ACTIVE) else $error("abort missed");
	cover property ($rose(oe) && !$past(TEST_ACTIVE));
	cover property ($rose(TEST_ACTIVE));
	cover property ($fell(TEST_ACTIVE) && !oe);
endmodule
bind mrst_timer mrst_timer_checker #(.HOLD_CYCLES(HOLD_CYCLES), .LONG_PULSE(LONG_PULSE),
	.TEST_DELAY_CYCLES(TEST_DELAY_CYCLES), .TEST_WINDOW_CYCLES(TEST_WINDOW_CYCLES),
	.SHORT_PULSE_CYCLES(SHORT_PULSE_CYCLES), .LONG_PULSE_CYCLES(LONG_PULSE_CYCLES)) chk (.CLK_SYS, .RST,
	.FIRST_MANUAL_INPUT_N, .SECOND_MANUAL_INPUT_N, .RESET_OUT_N, .RESET_OUT_OE, .TEST_ACTIVE);
`default_nettype wire

/* File: bench/mrst_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench; the expected pulse count is kept beside the partner's count.
module mrst_timer_tb;
	localparam longint HOLD = 100;
	localparam longint TDLY = 30;
	// A shortened pulse keeps the run small; the width logic is the same at any length.
	localparam int PW = 200;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic f = 1'b1;
	logic s = 1'b1;
	wire logic rn;
	wire logic oe;
	wire logic ta;
	int cnt, w, lat, seed, bad_count, total_checks;
	int exp_cnt = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	mrst_timer #(.HOLD_CYCLES(HOLD), .TEST_DELAY_CYCLES(TDLY), .TEST_WINDOW_CYCLES(60),
		.SHORT_PULSE_CYCLES(PW)) uut (.CLK_SYS(clk),
		.RST(rst), .FIRST_MANUAL_INPUT_N(f), .SECOND_MANUAL_INPUT_N(s), .RESET_OUT_N(rn), .RESET_OUT_OE(oe),
		.TEST_ACTIVE(ta));
	mrst_proc proc (.clk(clk), .rn(rn), .oe(oe), .cnt(cnt), .w(w));
	task chk(input bit ok);
		total_checks++;
		if (!ok)
		begin
			bad_count++;
			$display("[ERR] %0t check failed", $time);
		end
	endtask
	task cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bounded wait, sampled at the falling edge so the outputs have settled.
	task wait_oe;
		lat = 0;
		while (oe !== 1'b1 && lat < 400)
		begin
			@(negedge clk);
			lat++;
		end
	endtask
	// First input low, a lead time, then test clock starting with a fall.
	task tmode(input int n);
		f <= 1'b0;
		cy(10);
		repeat (n)
		begin
			s <= 1'b0;
			cy(2);
			s <= 1'b1;
			cy(2);
		end
	endtask
	task test_done;
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// The ceiling allows for three whole pulses plus margin.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			test_done;
		end
	end
	// Main sequence.
	initial
	begin
		seed = 96;
		cy(3);
		rst <= 1'b0;
		cy(20);
		chk(cnt === 0 && oe === 1'b0);
		f <= 1'b0;
		cy(1 + ($random(seed) & 7));
		s <= 1'b0;
		wait_oe;
		chk(lat >= HOLD + 3 && lat <= HOLD + 6);
		exp_cnt++;
		cy(PW + 100);
		chk(cnt === exp_cnt && w >= PW && w <= PW + 2);
		// A random input bounces; the early rise must clear the count.
		for (int i = 0; i < 2; i++)
		begin
			{f, s} <= ($random(seed) & 1) ? 2'b10 : 2'b01;
			cy(5);
			{f, s} <= 2'b00;
			cy(i == 0 ? HOLD - 6 : 0);
		end
		wait_oe;
		chk(lat >= HOLD + 3 && lat <= HOLD + 6);
		exp_cnt++;
		cy(PW + 100);
		chk(cnt === exp_cnt);
		{f, s} <= 2'b11;
		cy(10);
		tmode(7);
		cy(TDLY + 60);
		@(negedge clk);
		chk(ta === 1'b0 && cnt === exp_cnt);
		cy(1);
		f <= 1'b1;
		cy(10);
		tmode(8);
		cy(5);
		@(negedge clk);
		chk(ta === 1'b1);
		cy(1);
		f <= 1'b1;
		cy(TDLY + 60);
		@(negedge clk);
		chk(ta === 1'b0 && oe === 1'b0);
		cy(10);
		tmode(8);
		wait_oe;
		chk(lat >= TDLY && lat <= TDLY + 6);
		@(negedge clk);
		chk(ta === 1'b0);
		exp_cnt++;
		cy(1);
		f <= 1'b1;
		cy(PW + 100);
		chk(cnt === exp_cnt);
		test_done;
	end
endmodule
`default_nettype wire

/* File: hdl/mrst_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module mrst_sync (
	input wire logic CLK_SYS, // System clock.
	input wire logic RST, // Synchronous reset.
	input wire logic first_in_n, // Raw first manual input.
	input wire logic second_in_n, // Raw second manual input.
	output mrst_pkg::inputs_t ev // Clean levels and edges.
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] lvl;
	} sync_st_t;
	sync_st_t q, d;

	// ==========================================================
	// Three-stage synchroniser; edges come only from the second stage onward.
	always_comb
	begin
		d.s1 = {second_in_n, first_in_n};
		d.s2 = q.s1;
		d.lvl = q.s2; // [R14]
		if (RST)
		begin
			d.s1 = 2'h3;
			d.s2 = 2'h3;
			d.lvl = 2'h3;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		q <= d;
	end

	// Levels and edges are decoded from the stages after the first.
	always_comb
	begin
		ev.first_low = ~q.lvl[0];
		ev.second_low = ~q.lvl[1];
		ev.first_fall = q.lvl[0] & ~q.s2[0];
		ev.second_fall = q.lvl[1] & ~q.s2[1];
		ev.second_rise = ~q.lvl[1] & q.s2[1];
	end
endmodule
`default_nettype wire

/* File: hdl/mrst_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module mrst_timer #(
	parameter longint HOLD_CYCLES = mrst_pkg::HOLD_CYC,
	parameter bit LONG_PULSE = 1'b0,
	parameter longint TEST_DELAY_CYCLES = mrst_pkg::TEST_DELAY_CYC,
	parameter longint TEST_WINDOW_CYCLES = mrst_pkg::TEST_WINDOW_CYC,
	parameter longint SHORT_PULSE_CYCLES = mrst_pkg::SHORT_PULSE_CYC,
	parameter longint LONG_PULSE_CYCLES = mrst_pkg::LONG_PULSE_CYC
) (
	input wire logic CLK_SYS, // System clock, 125 MHz.
	input wire logic RST, // Synchronous reset, active high.
	input wire logic FIRST_MANUAL_INPUT_N, // First manual input, active low.
	input wire logic SECOND_MANUAL_INPUT_N, // Second manual input, active low.
	output logic RESET_OUT_N, // Open-drain reset output level, always low when driven.
	output logic RESET_OUT_OE, // High while the reset pin is pulled low.
	output logic TEST_ACTIVE // High while accelerated test mode is confirmed.
);
	localparam longint PULSE_CYCLES = LONG_PULSE ? LONG_PULSE_CYCLES : SHORT_PULSE_CYCLES;
	localparam logic [mrst_pkg::CNT_W-1:0] HOLD_END = mrst_pkg::CNT_W'(HOLD_CYCLES - 1);
	localparam logic [mrst_pkg::CNT_W-1:0] PULSE_END = mrst_pkg::CNT_W'(PULSE_CYCLES - 1);
	localparam logic [mrst_pkg::CNT_W-1:0] DELAY_END = mrst_pkg::CNT_W'(TEST_DELAY_CYCLES - 1);
	localparam logic [mrst_pkg::CNT_W-1:0] WIN_END = mrst_pkg::CNT_W'(TEST_WINDOW_CYCLES - 1);
	localparam logic [3:0] PULSES_END = 4'(mrst_pkg::TEST_PULSES);

	initial
	begin
		if (HOLD_CYCLES < 1 || TEST_DELAY_CYCLES < 1 || TEST_WINDOW_CYCLES < 1 || PULSE_CYCLES < 1
			|| PULSE_CYCLES >= (64'h1 << mrst_pkg::CNT_W)
			|| HOLD_CYCLES >= (64'h1 << mrst_pkg::CNT_W))
		begin
			$error("mrst_timer: counts out of range");
		end
	end

	typedef struct packed {
		mrst_pkg::mode_t mode;
		logic [mrst_pkg::CNT_W-1:0] cnt;
		logic [mrst_pkg::CNT_W-1:0] win;
		logic [3:0] pulses;
		logic seeking;
		logic armed_test;
		logic oe;
		logic test;
	} state_t;
	state_t q, d;
	mrst_pkg::inputs_t ev;
	logic both_low;
	logic both_high;

	// ==========================================================
	// Input conditioning.
	mrst_sync u_sync (
		.CLK_SYS(CLK_SYS),
		.RST(RST),
		.first_in_n(FIRST_MANUAL_INPUT_N),
		.second_in_n(SECOND_MANUAL_INPUT_N),
		.ev(ev)
	);

	assign both_low = ev.first_low & ev.second_low;
	assign both_high = ~ev.first_low & ~ev.second_low;

	// ==========================================================
	// Main sequencer.
	// Test-mode detection runs beside the hold timer: while the first input is
	// low, second-input pulses are counted in a 35 us window opened by the
	// first falling edge of the second input.
	always_comb
	begin
		d = q;
		d.oe = 1'b0;
		// Pulse detector for test-mode entry.
		if (q.mode != mrst_pkg::ST_TEST && q.mode != mrst_pkg::ST_PULSE)
		begin
			if (!ev.first_low)
			begin
				d.seeking = 1'b0;
				d.pulses = 4'h0;
			end
			else if (!q.seeking && ev.second_fall)
			begin
				d.seeking = 1'b1;
				d.pulses = 4'h0;
				d.win = '0;
			end
			else if (q.seeking)
			begin
				d.win = q.win + 1'b1;
				if (ev.second_rise)
				begin
					d.pulses = q.pulses + 4'h1;
				end
				if (q.win == WIN_END)
				begin
					d.seeking = 1'b0; // [R09]
				end
			end
		end
		case (q.mode)
			mrst_pkg::ST_IDLE:
			begin
				d.cnt = '0;
				if (both_low)
				begin
					d.mode = mrst_pkg::ST_HOLD; // [R02]
				end
			end
			mrst_pkg::ST_HOLD:
			begin
				d.cnt = q.cnt + 1'b1;
				if (!both_low)
				begin
					d.mode = mrst_pkg::ST_IDLE; // [R03]
					d.cnt = '0;
				end
				else if (q.cnt == HOLD_END)
				begin
					d.mode = mrst_pkg::ST_PULSE; // [R01]
					d.cnt = '0;
					d.oe = 1'b1; // [R06]
				end
			end
			mrst_pkg::ST_DONE:
			begin
				// Stays silent while both stay low; a new fall rearms.
				if (ev.first_fall || ev.second_fall)
				begin
					d.mode = mrst_pkg::ST_IDLE; // [R05]
				end
				else if (!both_low)
				begin
					d.mode = mrst_pkg::ST_IDLE; // [R04]
				end
			end
			mrst_pkg::ST_TEST:
			begin
				d.cnt = q.cnt + 1'b1;
				if (both_high)
				begin
					d.mode = mrst_pkg::ST_IDLE; // [R12]
					d.test = 1'b0;
					d.cnt = '0;
				end
				else if (q.cnt == DELAY_END)
				begin
					d.mode = mrst_pkg::ST_PULSE; // [R10]
					d.test = 1'b0; // [R11]
					d.armed_test = 1'b1;
					d.cnt = '0;
					d.oe = 1'b1;
				end
			end
			mrst_pkg::ST_PULSE:
			begin
				d.oe = 1'b1; // [R13]
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == PULSE_END)
				begin
					d.oe = 1'b0;
					d.cnt = '0;
					d.test = 1'b0; // [R11]
					d.armed_test = 1'b0;
					d.mode = q.armed_test ? mrst_pkg::ST_IDLE : mrst_pkg::ST_DONE;
				end
			end
			default:
			begin
				d.mode = mrst_pkg::ST_IDLE;
				d.cnt = '0;
			end
		endcase
		// Eighth rising edge inside the window confirms test mode.
		if (q.seeking && ev.second_rise && q.pulses == PULSES_END - 4'h1
			&& q.mode != mrst_pkg::ST_PULSE)
		begin
			d.mode = mrst_pkg::ST_TEST; // [R09]
			d.test = 1'b1;
			d.seeking = 1'b0;
			d.pulses = 4'h0;
			d.cnt = '0;
			d.oe = 1'b0;
		end
		// Power-up state: output released, nothing pending.
		if (RST)
		begin
			d.mode = mrst_pkg::ST_IDLE; // [R07]
			d.cnt = '0;
			d.win = '0;
			d.pulses = 4'h0;
			d.seeking = 1'b0;
			d.armed_test = 1'b0;
			d.oe = 1'b0;
			d.test = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		q <= d;
	end

	// ==========================================================
	// Outputs straight from flip-flops; the pin level is always low and
	// only the enable moves, as an open-drain driver should.
	always_ff @(posedge CLK_SYS)
	begin
		RESET_OUT_N <= 1'b0;
	end
	assign RESET_OUT_OE = q.oe;
	assign TEST_ACTIVE = q.test;
endmodule
`default_nettype wire

/* File: pkg/mrst_pkg.sv */
// Behaviour
// R01: One reset pulse is issued only after both manual inputs have stayed low for the whole hold timeout.
// R02: The inputs may fall in any order, and the hold count starts when the second of them goes low.
// R03: If either input rises before the count ends, the timer clears and waits for both inputs low again.
// R04: After a pulse, no further pulse is issued while both inputs stay low. After a test-mode pulse the code goes to ST_IDLE and can pulse again.
// R05: A fresh falling edge on either input restarts the timer and rearms the generator.
// R06: When the count ends, the open-drain reset output is driven low for the variant's pulse width.
// R07: At power-up the reset output stays released and no pulse is generated.
// R08: To request test mode, the far side holds the first input low and then clocks the second input at about 1 MHz, starting with a falling edge.
// R09: Test mode is confirmed only when 8 pulses arrive on the second input within a 35 us window.
// R10: In test mode a standard pulse follows about 250 us after the rising edge of the eighth pulse, whatever the hold timeout.
// R11: After the test-mode pulse, the block leaves test mode and resumes normal operation.
// R12: If both inputs are high at any moment during test mode, test mode is abandoned at once.
// R13: The pulse width is 2.2 ms for the short variant and 70 ms for the long variant.
// R14: Both inputs are synchronised before use so that the timer and pulse counter see clean edges.
package mrst_pkg;

	// ==========================================================
	// Timing
	localparam longint CLK_HZ = 125000000;
	localparam longint HOLD_MS = 500;
	localparam longint SHORT_PULSE_US = 2200;
	localparam longint LONG_PULSE_US = 70000;
	localparam longint TEST_WINDOW_US = 35;
	localparam longint TEST_DELAY_US = 250;
	localparam int TEST_PULSES = 8;
	localparam longint HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
	localparam longint SHORT_PULSE_CYC = SHORT_PULSE_US * (CLK_HZ / 1000000);
	localparam longint LONG_PULSE_CYC = LONG_PULSE_US * (CLK_HZ / 1000000);
	localparam longint TEST_WINDOW_CYC = TEST_WINDOW_US * (CLK_HZ / 1000000);
	localparam longint TEST_DELAY_CYC = TEST_DELAY_US * (CLK_HZ / 1000000);
	localparam int CNT_W = 32;

	// ==========================================================
	// States
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_HOLD = 5'h02,
		ST_DONE = 5'h04,
		ST_TEST = 5'h08,
		ST_PULSE = 5'h10
	} mode_t;

	typedef struct packed {
		logic first_low;
		logic second_low;
		logic first_fall;
		logic second_fall;
		logic second_rise;
	} inputs_t;

endpackage
